// >>> hw/host_dma_burst_release_control.sv
//==========================================================
// Host bus ownership for block DMA
//==========================================================
module host_dma_burst_release_control
   import dma_bus_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst,
   input wire logic block_start,
   input wire logic [COUNT_W-1:0] block_len,
   input wire logic [COUNT_W-1:0] burst_len,
   input wire logic cycle_steal,
   input wire logic host_hold_grant,
   input wire logic bus_release_request_n,
   output logic host_hold_request,
   output logic host_bus_owned_n,
   output logic bus_drive_en,
   output logic address_latch_strobe,
   output logic block_busy,
   output logic block_done
);
   bus_state_t state;
   bus_state_t next_state;
   logic [COUNT_W-1:0] remain;
   logic [COUNT_W-1:0] next_remain;
   logic [COUNT_W-1:0] burst_left;
   logic [COUNT_W-1:0] next_burst_left;
   logic [COUNT_W-1:0] burst_cfg;
   logic [COUNT_W-1:0] next_burst_cfg;
   logic steal;
   logic next_steal;
   logic next_hold;
   logic next_owned_n;
   logic next_drive;
   logic next_busy;
   logic next_block_done;
   logic xfer_start;
   logic xfer_strobe;
   logic xfer_done;
   logic [COUNT_W-1:0] burst_load;

   xfer_cycle u_cycle (
      .core_clk(core_clk),
      .rst(rst),
      .start(xfer_start),
      .strobe(xfer_strobe),
      .done(xfer_done)
   );

   // Without cycle steal, zero length configured means whole remainder in one burst
   always_comb begin
      if (steal)
         burst_load = COUNT_ONE;
      else if (burst_cfg == COUNT_ZERO || burst_cfg > remain)
         burst_load = remain;
      else
         burst_load = burst_cfg;
   end

   //==========================================================
   // Ownership sequencing
   //==========================================================
   always_comb begin
      next_state = state;
      next_remain = remain;
      next_burst_left = burst_left;
      next_burst_cfg = burst_cfg;
      next_steal = steal;
      next_hold = host_hold_request;
      next_owned_n = host_bus_owned_n;
      next_drive = bus_drive_en;
      next_busy = block_busy;
      next_block_done = 1'b0;
      xfer_start = 1'b0;
      case (state)
         ST_IDLE: begin
            if (block_start && block_len != COUNT_ZERO) begin
               next_remain = block_len;
               next_burst_cfg = burst_len;
               next_steal = cycle_steal;
               next_busy = 1'b1;
               next_hold = 1'b1;
               next_state = ST_REQ;
            end
         end
         ST_REQ: begin
            // Grant alone is enough to take the bus and start cycles
            if (host_hold_grant) begin
               next_owned_n = 1'b0;
               next_drive = 1'b1;
               next_burst_left = burst_load;
               next_state = ST_XFER;
            end
         end
         ST_XFER: begin
            xfer_start = 1'b1;
            next_state = ST_DONE;
         end
         ST_DONE: begin
            if (xfer_done) begin
               next_remain = remain - COUNT_ONE;
               next_burst_left = burst_left - COUNT_ONE;
               // Release sampled at cycle end so no cycle is cut short
               if (remain == COUNT_ONE || burst_left == COUNT_ONE ||
                   !bus_release_request_n) begin
                  next_hold = 1'b0;
                  next_drive = 1'b0;
                  next_state = ST_FLOAT;
               end else begin
                  next_state = ST_XFER;
               end
            end
         end
         ST_FLOAT: begin
            // Outputs already floated one cycle before ownership drops
            next_owned_n = 1'b1;
            if (remain != COUNT_ZERO) begin
               next_hold = 1'b1;
               next_state = ST_REQ;
            end else begin
               next_busy = 1'b0;
               next_block_done = 1'b1;
               next_state = ST_IDLE;
            end
         end
         default: begin
            next_state = ST_IDLE;
            next_hold = 1'b0;
            next_owned_n = 1'b1;
            next_drive = 1'b0;
            next_busy = 1'b0;
         end
      endcase
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         state <= ST_IDLE;
         remain <= COUNT_ZERO;
         burst_left <= COUNT_ZERO;
         burst_cfg <= COUNT_ZERO;
         steal <= 1'b0;
         host_hold_request <= 1'b0;
         host_bus_owned_n <= 1'b1;
         bus_drive_en <= 1'b0;
         address_latch_strobe <= 1'b0;
         block_busy <= 1'b0;
         block_done <= 1'b0;
      end else begin
         state <= next_state;
         remain <= next_remain;
         burst_left <= next_burst_left;
         burst_cfg <= next_burst_cfg;
         steal <= next_steal;
         host_hold_request <= next_hold;
         host_bus_owned_n <= next_owned_n;
         bus_drive_en <= next_drive;
         address_latch_strobe <= xfer_strobe;
         block_busy <= next_busy;
         block_done <= next_block_done;
      end
   end

   //==========================================================
   // Checks
   //==========================================================
   a_own_needs_grant: assert property (@(posedge core_clk) disable iff (rst)
      $fell(host_bus_owned_n) |-> $past(host_hold_grant) && host_hold_request)
      else $error("bus owned without grant");
   a_drive_with_own: assert property (@(posedge core_clk) disable iff (rst)
      bus_drive_en |-> !host_bus_owned_n)
      else $error("host bus driven without ownership");
   // Hold request is already back up when ownership drops mid-block, so look one cycle back
   a_float_before_own: assert property (@(posedge core_clk) disable iff (rst)
      $rose(host_bus_owned_n) |-> !bus_drive_en && !$past(bus_drive_en)
      && !$past(host_hold_request))
      else $error("bus-owned rose while still driving");
   a_strobe_owned: assert property (@(posedge core_clk) disable iff (rst)
      address_latch_strobe |-> !host_bus_owned_n && bus_drive_en)
      else $error("strobe outside ownership");
   a_release_honoured: assert property (@(posedge core_clk) disable iff (rst)
      (state == ST_DONE && xfer_done && !bus_release_request_n)
      |-> ##2 host_bus_owned_n)
      else $error("release request not honoured");
   a_rerequest_fast: assert property (@(posedge core_clk) disable iff (rst)
      $rose(host_bus_owned_n) && block_busy |-> host_hold_request)
      else $error("no re-request after release");
   a_steal_single: assert property (@(posedge core_clk) disable iff (rst)
      steal && address_latch_strobe |-> ##1 !address_latch_strobe [*3]
      ##1 (!address_latch_strobe && host_bus_owned_n))
      else $error("cycle steal kept the bus past one transfer");
   a_burst_limit: assert property (@(posedge core_clk) disable iff (rst)
      state == ST_XFER && burst_cfg != COUNT_ZERO |-> burst_left <= burst_cfg)
      else $error("burst exceeds configured length");

   // Strobes inside the current ownership; cleared whenever the bus is given back
   logic [COUNT_W-1:0] own_strobes;
   logic [COUNT_W-1:0] next_own_strobes;

   always_comb begin
      next_own_strobes = own_strobes;
      if (host_bus_owned_n)
         next_own_strobes = COUNT_ZERO;
      else if (address_latch_strobe)
         next_own_strobes = own_strobes + COUNT_ONE;
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst)
         own_strobes <= COUNT_ZERO;
      else
         own_strobes <= next_own_strobes;
   end

   a_burst_count: assert property (@(posedge core_clk) disable iff (rst)
      !steal && burst_cfg != COUNT_ZERO |-> own_strobes <= burst_cfg)
      else $error("more strobes in one ownership than the burst length");
   // Release input as the sequencer saw it at the end of the last transfer
   a_whole_block: assert property (@(posedge core_clk) disable iff (rst)
      $rose(host_bus_owned_n) && !steal && burst_cfg == COUNT_ZERO
      && $past(bus_release_request_n, 2) |-> !block_busy)
      else $error("zero burst length released early");
   c_block_done: cover property (@(posedge core_clk) disable iff (rst) block_done);
   c_forced_release: cover property (@(posedge core_clk) disable iff (rst)
      !bus_release_request_n && $rose(host_bus_owned_n) && block_busy);
   c_steal: cover property (@(posedge core_clk) disable iff (rst)
      steal && address_latch_strobe);
   c_split_burst: cover property (@(posedge core_clk) disable iff (rst)
      burst_cfg != COUNT_ZERO && !steal && $rose(host_bus_owned_n) && block_busy);
endmodule : host_dma_burst_release_control

// >>> hw/dma_bus_pkg.sv
//==========================================================
//==========================================================
package dma_bus_pkg;
   localparam int COUNT_W = 16;
   localparam int CYC_W = 2;
   localparam logic [CYC_W-1:0] XFER_CYCLES = 2'h3;
   localparam logic [CYC_W-1:0] CYC_ZERO = 2'h0;
   localparam logic [COUNT_W-1:0] COUNT_ZERO = 16'h0000;
   localparam logic [COUNT_W-1:0] COUNT_ONE = 16'h0001;
   localparam int REFRESH_NS = 15500;
   localparam int CLK_NS = 100;
   localparam int REFRESH_CYCLES = REFRESH_NS / CLK_NS;
   localparam int EXT_BURST_LIMIT = 15;

   typedef enum logic [2:0] {
      ST_IDLE = 3'h0,
      ST_REQ = 3'h1,
      ST_XFER = 3'h3,
      ST_DONE = 3'h2,
      ST_FLOAT = 3'h6
   } bus_state_t;
endpackage : dma_bus_pkg

// >>> hw/xfer_cycle.sv
//==========================================================
// Single transfer timing
//==========================================================
module xfer_cycle
   import dma_bus_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst,
   input wire logic start,
   output logic strobe,
   output logic done
);
   logic [CYC_W-1:0] cnt;
   logic [CYC_W-1:0] next_cnt;
   logic next_strobe;
   logic next_done;

   always_comb begin
      next_cnt = cnt;
      next_strobe = 1'b0;
      next_done = 1'b0;
      if (start && cnt == CYC_ZERO) begin
         next_cnt = XFER_CYCLES;
         next_strobe = 1'b1;
      end else if (cnt != CYC_ZERO) begin
         next_cnt = cnt - 2'h1;
         next_done = (cnt == 2'h1);
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         cnt <= CYC_ZERO;
         strobe <= 1'b0;
         done <= 1'b0;
      end else begin
         cnt <= next_cnt;
         strobe <= next_strobe;
         done <= next_done;
      end
   end
endmodule : xfer_cycle

// >>> testbench/bus_partner.sv
module bus_partner
   import dma_bus_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst,
   input wire logic host_hold_request,
   input wire logic host_bus_owned_n,
   input wire logic address_latch_strobe,
   input wire logic [3:0] grant_wait,
   input wire logic [4:0] strobe_limit,
   output logic host_hold_grant,
   output logic bus_release_request_n
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [3:0] wait_cnt;
   logic [4:0] strobe_cnt;
   //==========================================
   // Arbiter and burst counter
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         wait_cnt <= 4'h0;
         host_hold_grant <= 1'b0;
         strobe_cnt <= 5'h00;
         bus_release_request_n <= 1'b1;
      end else begin
         if (!host_hold_request) begin
            wait_cnt <= 4'h0;
            host_hold_grant <= 1'b0;
         end else if (wait_cnt == grant_wait) begin
            host_hold_grant <= 1'b1;
         end else begin
            wait_cnt <= wait_cnt + 4'h1;
         end
         // Limit 0 turns the counter off
         if (host_bus_owned_n) begin
            strobe_cnt <= 5'h00;
            bus_release_request_n <= 1'b1;
         end else if (address_latch_strobe && strobe_limit != 5'h00) begin
            strobe_cnt <= strobe_cnt + 5'h01;
            if (strobe_cnt + 5'h01 == strobe_limit) begin
               bus_release_request_n <= 1'b0;
            end
         end
      end
   end
endmodule : bus_partner

// >>> testbench/host_dma_burst_release_control_tb.sv
module host_dma_burst_release_control_tb;
   import dma_bus_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   logic core_clk, rst, block_start, cycle_steal, grant, rel_n;
   logic [COUNT_W-1:0] block_len, burst_len;
   logic hold, owned_n, drive_en, strobe, busy, done;
   logic prev_owned_n, prev_hold, prev_drive;
   logic [3:0] grant_wait;
   logic [4:0] strobe_limit;
   logic [15:0] n_strobe, n_own, n_done, n_bad;
   logic [15:0] own_span, max_span;
   int fails, n_checks;
   host_dma_burst_release_control uut (.core_clk(core_clk), .rst(rst),
      .block_start(block_start), .block_len(block_len), .burst_len(burst_len),
      .cycle_steal(cycle_steal), .host_hold_grant(grant), .bus_release_request_n(rel_n),
      .host_hold_request(hold), .host_bus_owned_n(owned_n), .bus_drive_en(drive_en),
      .address_latch_strobe(strobe), .block_busy(busy), .block_done(done));
   bus_partner partner (.core_clk(core_clk), .rst(rst), .host_hold_request(hold),
      .host_bus_owned_n(owned_n), .address_latch_strobe(strobe), .grant_wait(grant_wait),
      .strobe_limit(strobe_limit), .host_hold_grant(grant), .bus_release_request_n(rel_n));
   //==========================================
   // Bus watcher, sampled where outputs are settled
   always @(negedge core_clk) begin
      if (rst) begin
         {n_strobe, n_own, n_done, n_bad} <= 64'h0;
         {own_span, max_span} <= 32'h0;
      end else begin
         if (strobe === 1'b1) n_strobe <= n_strobe + 16'h0001;
         if (done === 1'b1) n_done <= n_done + 16'h0001;
         if (prev_owned_n === 1'b1 && owned_n === 1'b0) n_own <= n_own + 16'h0001;
         if (strobe === 1'b1 && (owned_n !== 1'b0 || drive_en !== 1'b1))
            n_bad <= n_bad + 16'h0001;
         if (prev_owned_n === 1'b0 && owned_n === 1'b1 && (prev_hold || prev_drive))
            n_bad <= n_bad + 16'h0001;
         if (owned_n === 1'b0) own_span <= own_span + 16'h0001;
         else own_span <= 16'h0000;
         if (own_span > max_span) max_span <= own_span;
      end
      prev_owned_n <= owned_n;
      prev_hold <= hold;
      prev_drive <= drive_en;
   end
   initial begin
      core_clk = 1'b0;
      forever #50 core_clk = ~core_clk;
   end
   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      n_checks++;
      if (seen !== exp) begin
         fails++;
         $display("FAIL %s expected %0h seen %0h", name, exp, seen);
      end
   endtask : check
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : report_and_stop
   // Runs one block and compares strobe and ownership counts
   task automatic run(input logic [15:0] len, input logic [15:0] bl, input logic cs,
                      input logic [4:0] lim, input logic [3:0] gw, input logic [15:0] own);
      logic [15:0] s_strobe, s_own, s_done, s_bad;
      @(negedge core_clk);
      {s_strobe, s_own, s_done, s_bad} = {n_strobe, n_own, n_done, n_bad};
      block_len = len;
      burst_len = bl;
      cycle_steal = cs;
      strobe_limit = lim;
      grant_wait = gw;
      block_start = 1'b1;
      @(negedge core_clk);
      block_start = 1'b0;
      check("busy", {15'h0000, busy}, 16'h0001);
      for (int i = 0; i < 3000 && done !== 1'b1; i++) @(negedge core_clk);
      repeat (3) @(negedge core_clk);
      check("strobes", n_strobe - s_strobe, len);
      check("ownerships", n_own - s_own, own);
      check("done", n_done - s_done, 16'h0001);
      check("order", n_bad - s_bad, 16'h0000);
      check("idle", {14'h0000, hold, owned_n}, 16'h0001);
   endtask : run
   task automatic whole_block();
      run(16'h0005, 16'h0000, 1'b0, 5'h00, 4'h0, 16'h0001);
   endtask : whole_block
   task automatic split_bursts();
      run(16'h0007, 16'h0003, 1'b0, 5'h00, 4'h5, 16'h0003);
   endtask : split_bursts
   task automatic steal_cycles();
      run(16'h0004, 16'h0000, 1'b1, 5'h00, 4'h2, 16'h0004);
   endtask : steal_cycles
   task automatic forced_release();
      run(16'h0014, 16'h0000, 1'b0, 5'(EXT_BURST_LIMIT), 4'h1, 16'h0002);
      check("burst span", {15'h0000, max_span <= 16'(REFRESH_CYCLES)}, 16'h0001);
   endtask : forced_release
   initial begin
      rst = 1'b1;
      {block_start, cycle_steal} = 2'b00;
      {block_len, burst_len} = 32'h0;
      {grant_wait, strobe_limit} = 9'h000;
      fails = 0;
      n_checks = 0;
      repeat (8) @(negedge core_clk);
      rst = 1'b0;
      whole_block();
      split_bursts();
      steal_cycles();
      forced_release();
      report_and_stop();
   end
   // Four blocks need well under 2000 cycles
   initial begin
      repeat (20000) @(posedge core_clk);
      fails++;
      report_and_stop();
   end
endmodule : host_dma_burst_release_control_tb
